// ==== hw/tlhc_top.sv ====
/*
 lower 32-bit half of a general purpose timer with its control word,
 period, reload and arrangement registers on apb. assumes a single
 100 MHz clock and an asynchronous timer input pin.
*/
`timescale 1ns/1ps
module tlhc_top
(
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        TIMER_IN,
	output logic             TIMER_EVENT_IRQ,
	output logic             TIMER_EVENT_DMA,
	output logic             TIMER_EVENT_OUT
);
	typedef struct packed
	{
		logic [31:0] control;
		logic [31:0] count;
		logic [31:0] period;
		logic [31:0] reload;
		logic [1:0]  arrange;
		logic        wrap;
		logic        stopped;
		logic        evt;
		logic [31:0] rdata;
		logic        slverr;
	} tlhc_state_s;

	tlhc_state_s st_reg;
	tlhc_state_s st_next;

	logic       pin_level;
	logic       pin_rise;
	logic       pin_fall;
	logic       cap_hit;
	logic [1:0] run_mode;
	logic       src_pin;
	logic       cap_en;
	logic       rd_clr_en;
	logic       unchained;
	logic       cap_ok;
	logic       tick;
	logic       access;
	logic       wr;
	logic       rd;
	logic       mapped;

	tlhc_sync u_sync
	(
		.clk    (CLK),
		.rst_b  (RST_B),
		.pin_in (TIMER_IN),
		.level  (pin_level),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	tlhc_evsel u_evsel
	(
		.rise      (pin_rise),
		.fall      (pin_fall),
		.edge_sel  (st_reg.control[tlhc_pkg::POS_EDGE +: 2]),
		.event_hit (cap_hit)
	);

	function automatic logic addr_is(input logic [11:0] a,
		input logic [11:0] off);
		addr_is = (a == off);
	endfunction : addr_is

	assign run_mode  = st_reg.control[tlhc_pkg::POS_RUN +: 2];
	assign src_pin   = st_reg.control[tlhc_pkg::POS_SRC];
	assign cap_en    = st_reg.control[tlhc_pkg::POS_CAP_EN];
	assign rd_clr_en = st_reg.control[tlhc_pkg::POS_RD_CLR];
	assign unchained = (st_reg.arrange == tlhc_pkg::ARR_DUAL_UNCHAINED);
	// capture qualified by arrangement, source and mode
	assign cap_ok    = cap_en & unchained & ~src_pin & run_mode[1];
	// count tick: every clock internally, rising pin edge externally
	assign tick      = src_pin ? pin_rise : 1'b1;
	assign access    = PSEL & PENABLE;
	assign wr        = access & PWRITE;
	assign rd        = access & ~PWRITE;
	assign mapped    = addr_is(PADDR, tlhc_pkg::OFF_CONTROL)
		| addr_is(PADDR, tlhc_pkg::OFF_COUNT)
		| addr_is(PADDR, tlhc_pkg::OFF_PERIOD)
		| addr_is(PADDR, tlhc_pkg::OFF_RELOAD)
		| addr_is(PADDR, tlhc_pkg::OFF_ARRANGE)
		| addr_is(PADDR, tlhc_pkg::OFF_STATUS);

	always_comb
	begin
		st_next     = st_reg;
		st_next.evt = 1'b0;
		// counting; in the continuous modes wrap flags the cycle right after a period match
		st_next.wrap = 1'b0;
		if (tick)
		begin
			unique case (tlhc_pkg::tlhc_run_e'(run_mode))
				tlhc_pkg::RUN_DISABLED:
					st_next.count = st_reg.count;
				tlhc_pkg::RUN_ONCE:
				begin
					if (st_reg.count == st_reg.period)
					begin
						if (!st_reg.stopped)
							st_next.evt = 1'b1;
						st_next.stopped = 1'b1;
					end
					else if (!st_reg.stopped)
						st_next.count = st_reg.count + 32'h0000_0001;
				end
				tlhc_pkg::RUN_CONTINUOUS,
				tlhc_pkg::RUN_CONT_RELOAD:
				begin
					if (st_reg.count == st_reg.period)
					begin
						st_next.count = '0;
						st_next.wrap  = 1'b1;
						st_next.evt   = 1'b1;
						if (run_mode == tlhc_pkg::RUN_CONT_RELOAD)
							st_next.period = st_reg.reload;
					end
					else
						st_next.count = st_reg.count + 32'h0000_0001;
				end
			endcase
		end
		// capture: clear counter and raise events
		if (cap_ok && cap_hit)
		begin
			st_next.count = '0;
			st_next.wrap  = 1'b0;
			st_next.evt   = 1'b1;
		end
		// register writes
		st_next.slverr = 1'b0;
		if (wr && mapped)
		begin
			if (addr_is(PADDR, tlhc_pkg::OFF_CONTROL))
			begin
				st_next.control = PWDATA & tlhc_pkg::CONTROL_MASK;
				st_next.stopped = 1'b0;
			end
			if (addr_is(PADDR, tlhc_pkg::OFF_COUNT))
				st_next.count = PWDATA;
			if (addr_is(PADDR, tlhc_pkg::OFF_PERIOD))
				st_next.period = PWDATA;
			if (addr_is(PADDR, tlhc_pkg::OFF_RELOAD))
				st_next.reload = PWDATA;
			if (addr_is(PADDR, tlhc_pkg::OFF_ARRANGE))
				st_next.arrange = PWDATA[tlhc_pkg::POS_ARRANGE +: 2];
		end
		// reads: counter read may clear without events
		st_next.rdata = tlhc_pkg::PSLVERR_DATA;
		if (rd && mapped)
		begin
			if (addr_is(PADDR, tlhc_pkg::OFF_CONTROL))
				st_next.rdata = st_reg.control;
			if (addr_is(PADDR, tlhc_pkg::OFF_COUNT))
			begin
				st_next.rdata = st_reg.count;
				if (rd_clr_en && unchained)
				begin
					// no event is raised here; capture events still pass
					st_next.count = '0;
					st_next.wrap  = 1'b0;
				end
			end
			if (addr_is(PADDR, tlhc_pkg::OFF_PERIOD))
				st_next.rdata = st_reg.period;
			if (addr_is(PADDR, tlhc_pkg::OFF_RELOAD))
				st_next.rdata = st_reg.reload;
			if (addr_is(PADDR, tlhc_pkg::OFF_ARRANGE))
				st_next.rdata = {28'h0000000, st_reg.arrange, 2'h0};
			if (addr_is(PADDR, tlhc_pkg::OFF_STATUS))
				st_next.rdata = {29'h00000000, pin_level,
					st_reg.stopped, st_reg.wrap};
		end
		if (access && !mapped)
			st_next.slverr = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			st_reg         <= '0;
			st_reg.control <= tlhc_pkg::RST_CONTROL;
			st_reg.count   <= tlhc_pkg::RST_COUNT;
			st_reg.period  <= tlhc_pkg::RST_PERIOD;
			st_reg.reload  <= tlhc_pkg::RST_RELOAD;
			st_reg.arrange <= tlhc_pkg::RST_ARRANGE;
		end
		else
			st_reg <= st_next;
	end

	// single-cycle access phase; read data comes from the bus path
	assign PREADY          = 1'b1;
	assign PRDATA          = rd ? st_next.rdata : 32'h0000_0000;
	assign PSLVERR         = access & ~mapped;
	assign TIMER_EVENT_IRQ = st_reg.evt;
	assign TIMER_EVENT_DMA = st_reg.evt;
	assign TIMER_EVENT_OUT = st_reg.evt;

	a_capture_clears: assert property (@(posedge CLK) disable iff (!RST_B)
		(cap_ok && cap_hit && !wr) |=> (st_reg.count == 32'h0) && st_reg.evt)
		else $error("capture did not clear counter");
	a_capture_gated: assert property (@(posedge CLK) disable iff (!RST_B)
		(cap_hit && (src_pin || !unchained || !run_mode[1]))
		|-> !cap_ok)
		else $error("capture allowed out of mode");
	a_cap_events: assert property (@(posedge CLK) disable iff (!RST_B)
		(cap_ok && cap_hit && !rd) |=> TIMER_EVENT_IRQ && TIMER_EVENT_DMA)
		else $error("capture gave no events");
	a_read_clears: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && addr_is(PADDR, tlhc_pkg::OFF_COUNT) && rd_clr_en && unchained
		&& !(cap_ok && cap_hit) && !(tick && run_mode != 2'b00
		&& st_reg.count == st_reg.period))
		|=> st_reg.count == 32'h0 && !st_reg.evt)
		else $error("read clear failed");
	a_read_keeps: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && !rd_clr_en && run_mode == 2'b00 && !st_reg.wrap && !cap_ok)
		|=> st_reg.count == $past(st_reg.count))
		else $error("read disturbed counter");
	a_wrap_zero: assert property (@(posedge CLK) disable iff (!RST_B)
		(run_mode[1] && tick && !access
		&& st_reg.count == st_reg.period) |=> st_reg.count == 32'h0)
		else $error("no wrap after match");
	a_reload_period: assert property (@(posedge CLK) disable iff (!RST_B)
		(run_mode == 2'b11 && tick && st_reg.count == st_reg.period && !wr)
		|=> st_reg.period == $past(st_reg.reload))
		else $error("period not reloaded");
	a_once_stops: assert property (@(posedge CLK) disable iff (!RST_B)
		(st_reg.stopped && run_mode == 2'b01 && !access && !cap_ok)
		|=> $stable(st_reg.count))
		else $error("one-shot kept counting");
	a_rsvd_zero: assert property (@(posedge CLK) disable iff (!RST_B)
		(st_reg.control & ~tlhc_pkg::CONTROL_MASK) == 32'h0)
		else $error("reserved control bit set");
	a_pin_source: assert property (@(posedge CLK) disable iff (!RST_B)
		(src_pin && !pin_rise && run_mode == 2'b10 && !st_reg.wrap
		&& !access && !(cap_ok && cap_hit)) |=> $stable(st_reg.count))
		else $error("counted without pin edge");
endmodule : tlhc_top

// ==== hw/tlhc_pkg.sv ====
/*
 timer lower half package: register offsets, control word fields,
 mode encodings and reset values. assumes an apb slave with 32-bit
 aligned words.
*/
package tlhc_pkg;
	// register byte offsets
	localparam logic [11:0] OFF_CONTROL      = 12'h000;
	localparam logic [11:0] OFF_COUNT        = 12'h004;
	localparam logic [11:0] OFF_PERIOD       = 12'h008;
	localparam logic [11:0] OFF_RELOAD       = 12'h00c;
	localparam logic [11:0] OFF_ARRANGE      = 12'h010;
	localparam logic [11:0] OFF_STATUS       = 12'h014;
	// control word and arrangement register field positions
	localparam int          POS_EDGE         = 12;
	localparam int          POS_CAP_EN       = 11;
	localparam int          POS_RD_CLR       = 10;
	localparam int          POS_SRC          = 8;
	localparam int          POS_RUN          = 6;
	localparam int          POS_ARRANGE      = 2;
	// writable bits of the control word and the arrangement register
	localparam logic [31:0] CONTROL_MASK     = 32'h0000_3dc0;
	localparam logic [31:0] ARRANGE_MASK     = 32'h0000_000c;
	// reset values, and the read data returned for unmapped addresses
	localparam logic [31:0] RST_CONTROL      = 32'h0000_0000;
	localparam logic [31:0] RST_COUNT        = 32'h0000_0000;
	localparam logic [31:0] RST_PERIOD       = 32'hffff_ffff;
	localparam logic [31:0] RST_RELOAD       = 32'h0000_0000;
	localparam logic [1:0]  RST_ARRANGE      = 2'h0;
	localparam logic [31:0] PSLVERR_DATA     = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		RUN_DISABLED   = 2'b00,
		RUN_ONCE       = 2'b01,
		RUN_CONTINUOUS = 2'b10,
		RUN_CONT_RELOAD = 2'b11
	} tlhc_run_e;

	typedef enum logic [1:0]
	{
		EDGE_RISING  = 2'b00,
		EDGE_FALLING = 2'b01,
		EDGE_BOTH    = 2'b10,
		EDGE_RSVD    = 2'b11
	} tlhc_edge_e;

	localparam logic [1:0]  ARR_DUAL_UNCHAINED = 2'h1;
endpackage : tlhc_pkg

// ==== hw/tlhc_sync.sv ====
/*
 two flip-flop synchroniser for the timer input pin, followed by
 rising and falling edge detection on the synchronised level.
 assumes the pin is asynchronous to CLK.
*/
`timescale 1ns/1ps
module tlhc_sync
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	typedef struct packed
	{
		logic meta;
		logic sync;
		logic last;
	} tlhc_sync_s;

	tlhc_sync_s st_reg;
	tlhc_sync_s st_next;

	always_comb
	begin
		st_next      = st_reg;
		st_next.meta = pin_in;
		st_next.sync = st_reg.meta;
		st_next.last = st_reg.sync;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign level = st_reg.sync;
	assign rise  = st_reg.sync & ~st_reg.last;
	assign fall  = ~st_reg.sync & st_reg.last;
endmodule : tlhc_sync

// ==== hw/tlhc_evsel.sv ====
/*
 capture edge selection: turns synchronised edges into a capture
 event according to the edge select code. assumes edges are
 one-cycle pulses on CLK.
*/
`timescale 1ns/1ps
module tlhc_evsel
(
	input  wire logic       rise,
	input  wire logic       fall,
	input  wire logic [1:0] edge_sel,
	output logic            event_hit
);
	always_comb
	begin
		unique case (tlhc_pkg::tlhc_edge_e'(edge_sel))
			tlhc_pkg::EDGE_RISING:  event_hit = rise;
			tlhc_pkg::EDGE_FALLING: event_hit = fall;
			tlhc_pkg::EDGE_BOTH:    event_hit = rise | fall;
			tlhc_pkg::EDGE_RSVD:    event_hit = 1'b0;
		endcase
	end
endmodule : tlhc_evsel

// ==== sim/tlhc_pin_model.sv ====
/*
 far-side model of the timer input pin: toggles the pin on request.
 assumes the caller runs in step with clk.
*/
`timescale 1ns/1ps
module tlhc_pin_model
(
	input  wire logic clk,
	output logic      pin
);
	initial pin = 1'b0;

	// each level held six cycles so the synchroniser sees it
	task automatic toggle(input int n);
		repeat (n)
		begin
			repeat (6) @(posedge clk);
			pin <= ~pin;
		end
		repeat (6) @(posedge clk);
	endtask : toggle
endmodule : tlhc_pin_model

// ==== sim/tlhc_top_test.sv ====
/*
 self-checking bench for the timer lower half over apb.
 assumes tlhc_pkg, tlhc_top and the pin model are compiled first.
*/
`timescale 1ns/1ps
module tlhc_top_test;
	logic        CLK;
	logic        RST_B;
	logic        PSEL;
	logic        PENABLE;
	logic        PWRITE;
	logic [11:0] PADDR;
	logic [31:0] PWDATA;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        TIMER_IN;
	logic        TIMER_EVENT_IRQ;
	logic        TIMER_EVENT_DMA;
	logic        TIMER_EVENT_OUT;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          ev_i = 0;
	int          ev_d = 0;
	int          ev_o = 0;
	int          e0;
	logic [31:0] rdat;
	logic        rerr;

	tlhc_top dut
	(
		.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.TIMER_IN(TIMER_IN), .TIMER_EVENT_IRQ(TIMER_EVENT_IRQ),
		.TIMER_EVENT_DMA(TIMER_EVENT_DMA),
		.TIMER_EVENT_OUT(TIMER_EVENT_OUT)
	);
	tlhc_pin_model pin_drv (.clk(CLK), .pin(TIMER_IN));

	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	always @(posedge CLK)
	begin
		cyc++;
		ev_i += (TIMER_EVENT_IRQ === 1'b1);
		ev_d += (TIMER_EVENT_DMA === 1'b1);
		ev_o += (TIMER_EVENT_OUT === 1'b1);
		if (cyc == 5000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	task give_verdict();
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one transfer; answer taken at the edge where pready is high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
		begin
			@(posedge CLK);
		end
		while (PREADY !== 1'b1);
		rdat = PRDATA;
		rerr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rdat, e);
	endtask : rdc

	task t_reset();
		rdc("ctl_rst", tlhc_pkg::OFF_CONTROL, 32'h0);
		rdc("prd_rst", tlhc_pkg::OFF_PERIOD, 32'hffff_ffff);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped_err", {31'h0, rerr}, 32'h1);
		wr(tlhc_pkg::OFF_CONTROL, 32'hffff_ffff);
		rdc("ctl_mask", tlhc_pkg::OFF_CONTROL, 32'h0000_3dc0);
		wr(tlhc_pkg::OFF_CONTROL, 32'h0);
		wr(tlhc_pkg::OFF_COUNT, 32'h5);
		repeat (10) @(posedge CLK);
		rdc("cnt_hold", tlhc_pkg::OFF_COUNT, 32'h5);
		rdc("cnt_keep", tlhc_pkg::OFF_COUNT, 32'h5);
	endtask : t_reset

	task t_mode(input int run, input int prd, input int lo, input int hi);
		wr(tlhc_pkg::OFF_COUNT, 32'h0);
		wr(tlhc_pkg::OFF_RELOAD, 32'h7);
		wr(tlhc_pkg::OFF_PERIOD, prd);
		e0 = ev_i;
		wr(tlhc_pkg::OFF_CONTROL, run << 6);
		repeat (60) @(posedge CLK);
		wr(tlhc_pkg::OFF_CONTROL, 32'h0);
		chk("mode_ev", (ev_i - e0 >= lo) && (ev_i - e0 <= hi), 32'h1);
	endtask : t_mode

	task t_readclr();
		wr(tlhc_pkg::OFF_COUNT, 32'h9);
		wr(tlhc_pkg::OFF_CONTROL, 32'h0400);
		rdc("rc_arr0", tlhc_pkg::OFF_COUNT, 32'h9);
		rdc("rc_arr0", tlhc_pkg::OFF_COUNT, 32'h9);
		wr(tlhc_pkg::OFF_ARRANGE, 32'h4);
		e0 = ev_i;
		rdc("rc_first", tlhc_pkg::OFF_COUNT, 32'h9);
		rdc("rc_clear", tlhc_pkg::OFF_COUNT, 32'h0);
		chk("rc_events", ev_i - e0, 32'h0);
	endtask : t_readclr

	task t_pin();
		wr(tlhc_pkg::OFF_COUNT, 32'h0);
		wr(tlhc_pkg::OFF_PERIOD, 32'hffff_ffff);
		wr(tlhc_pkg::OFF_CONTROL, 32'h0180);
		pin_drv.toggle(10);
		wr(tlhc_pkg::OFF_CONTROL, 32'h0);
		rdc("pin_count", tlhc_pkg::OFF_COUNT, 32'h5);
	endtask : t_pin

	// codes 0..3 with capture on, then capture off
	task t_capture();
		int exp_ev [5] = '{1, 1, 2, 0, 0};
		for (int c = 0; c < 5; c++)
		begin
			wr(tlhc_pkg::OFF_COUNT, 32'h0);
			e0 = ev_i;
			wr(tlhc_pkg::OFF_CONTROL, ((c % 4) << 12) | 32'h80
				| ((c < 4) ? 32'h800 : 32'h0));
			pin_drv.toggle(2);
			wr(tlhc_pkg::OFF_CONTROL, 32'h0);
			chk("cap_ev", ev_i - e0, exp_ev[c]);
		end
		chk("ev_dma", ev_d, ev_i);
		chk("ev_out", ev_o, ev_i);
	endtask : t_capture

	initial
	begin
		RST_B = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h0;
		PWDATA = 32'h0;
		repeat (20) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		t_reset();
		t_mode(1, 4, 1, 1);
		t_mode(2, 3, 14, 17);
		t_mode(3, 3, 7, 9);
		rdc("reload", tlhc_pkg::OFF_PERIOD, 32'h7);
		t_readclr();
		t_pin();
		t_capture();
		give_verdict();
	end
endmodule : tlhc_top_test
